// ===== shared/otg_pkg.sv
// Package of register map, field positions and timing for the OTG role block
package otg_pkg;

  // Register byte addresses on the APB
  localparam logic [7:0] status_addr  = 8'h00;
  localparam logic [7:0] control_addr = 8'h04;
  localparam logic [7:0] power_addr   = 8'h08;
  localparam logic [7:0] page_addr    = 8'h0c;
  localparam logic [7:0] role_addr    = 8'h10;
  localparam logic [7:0] role_st_addr = 8'h14;

  // Status register fields
  localparam int stat_plug_bit    = 7;
  localparam int stat_stable_bit  = 5;
  localparam int stat_sessvld_bit = 3;
  localparam int stat_sessend_bit = 2;
  localparam int stat_busvld_bit  = 0;

  // Control register fields
  localparam int con_dp_up_bit   = 7;
  localparam int con_dm_up_bit   = 6;
  localparam int con_dp_down_bit = 5;
  localparam int con_dm_down_bit = 4;
  localparam int con_bus_on_bit  = 3;
  localparam int con_otg_en_bit  = 2;
  localparam int con_chg_sel_bit = 1;
  localparam int con_dischg_bit  = 0;

  // Power register fields
  localparam int pwr_pending_bit = 7;
  localparam int pwr_guard_bit   = 4;
  localparam int pwr_suspend_bit = 1;
  localparam int pwr_enable_bit  = 0;
  localparam logic [7:0] pwr_write_mask = 8'h13;

  // Role register fields
  localparam int role_host_en_bit  = 0;
  localparam int role_func_en_bit  = 1;
  localparam int role_a_dev_bit    = 2;
  localparam int role_swap_ok_bit  = 3;
  localparam int role_low_spd_bit  = 4;
  localparam int role_resume_bit   = 5;
  localparam int role_bus_rst_bit  = 6;

  // Reset values
  localparam logic [7:0] control_rst = 8'h00;
  localparam logic [7:0] power_rst   = 8'h00;
  localparam logic [7:0] page_rst    = 8'h00;
  localparam logic [7:0] role_rst    = 8'h00;

  // Timing
  localparam longint clk_hz         = 20000000;
  localparam longint stable_time_us = 1000;
  localparam longint idle_time_us   = 3000;
  localparam int stable_cycles =
    int'((stable_time_us * clk_hz + 999999) / 1000000);
  localparam int idle_cycles =
    int'((idle_time_us * clk_hz + 999999) / 1000000);

  // Role negotiation states
  typedef enum logic [2:0] {
    st_idle,
    st_b_disc,
    st_b_host_rst,
    st_b_host,
    st_a_wait_idle,
    st_a_periph,
    st_a_host_rst
  } role_state_e;

endpackage : otg_pkg

// ===== rtl/line_idle_timer.sv
// Counter that measures how long a sampled line state stays unchanged
`timescale 1ns/1ps
module line_idle_timer #(
  parameter int limit = 20000
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic changed,
  output logic      reached
);

  typedef struct packed {
    logic [31:0] count;
    logic        reached;
  } timer_s;

  timer_s state_reg;
  timer_s state_next;

  // Restart on change, saturate at the limit
  always_comb begin
    state_next = state_reg;
    if (changed) begin
      state_next.count   = 32'h0;
      state_next.reached = 1'b0;
    end else if (state_reg.count < 32'(limit - 1)) begin
      state_next.count = state_reg.count + 32'h1;
    end else begin
      state_next.reached = 1'b1;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reached = state_reg.reached;

endmodule : line_idle_timer

// ===== rtl/otg_role_swap_power_control.sv
// Dual-role port control: role swap, status sensing, pulls, power, suspend
`timescale 1ns/1ps
// Behaviour
// - Role swap starts only at full speed
// - B-device drops both pull-ups during suspend
// - A-device grants host by D+ pull-up
// - A-device resume instead keeps host role
// - B-device on attach becomes host, resets bus
// - B-host ends: halt traffic, enable D+ pull-up
// - A-device after 3 ms idle drops pull-up
// - A-device on attach resumes host, resets
// - Only low byte implemented, upper reads zero
// - Plug bit: 1 none/B, 0 A plug
// - Line stable bit: no change for 1 ms
// - Session, session-end, bus-valid comparator bits
// - Control bits 7..4 enable pull resistors
// - Dual-role enable selects direct or hardware pulls
// - Bus power, charge level, discharge controls
// - Activity pending meaningful only with sleep guard
// - Suspend gates clock; hardware may clear it
// - Page register forces its lowest bit zero
module otg_role_swap_power_control (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        plug_type_sense,
  input  wire logic        line_se0,
  input  wire logic        line_j,
  input  wire logic        session_valid_cmp,
  input  wire logic        b_session_end_cmp,
  input  wire logic        a_bus_power_valid_cmp,
  input  wire logic        bus_reset_irq_flag,
  input  wire logic        attach_irq_flag,
  input  wire logic        bus_activity,
  input  wire logic        resume_seen,
  output logic             dplus_pullup_en,
  output logic             dminus_pullup_en,
  output logic             dplus_pulldown_en,
  output logic             dminus_pulldown_en,
  output logic             bus_power_on,
  output logic             bus_charge_level_sel,
  output logic             bus_power_discharge_en,
  output logic             usb_clock_gate,
  output logic             xcvr_low_power,
  output logic             bus_reset_drive,
  output logic             traffic_halt,
  output logic             host_active,
  output logic [7:0]       descriptor_table_page
);

  localparam int sync_w = 8;

  typedef struct packed {
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic [sync_w-1:0]       s1;
    logic [sync_w-1:0]       s2;
    logic [sync_w-1:0]       s3;
    logic [sync_w-1:0]       in_q;
    logic [7:0]              control;
    logic [7:0]              power;
    logic [7:0]              page;
    logic [7:0]              role;
    otg_pkg::role_state_e    fsm;
    logic                    pu_dp;
    logic                    pu_dm;
    logic                    pd_dp;
    logic                    pd_dm;
    logic                    vbus_on;
    logic                    chg_sel;
    logic                    dischg;
    logic                    clk_gate;
    logic                    low_pwr;
    logic                    rst_drv;
    logic                    halt;
    logic                    host;
  } ctl_s;

  ctl_s  st_reg;
  ctl_s  st_next;
  logic  stable_hit;
  logic  idle_hit;
  logic  line_changed;
  logic  bus_changed;

  // Decode a register address into a one-hot select
  function automatic logic [5:0] decode(input logic [7:0] a);
    if (a == otg_pkg::status_addr) begin
      decode = 6'h01;
    end else if (a == otg_pkg::control_addr) begin
      decode = 6'h02;
    end else if (a == otg_pkg::power_addr) begin
      decode = 6'h04;
    end else if (a == otg_pkg::page_addr) begin
      decode = 6'h08;
    end else if (a == otg_pkg::role_addr) begin
      decode = 6'h10;
    end else if (a == otg_pkg::role_st_addr) begin
      decode = 6'h20;
    end else begin
      decode = 6'h00;
    end
  endfunction : decode

  // Synchronised pins: plug, se0, j, sessvld, sessend, busvld, activity, resume
  logic [sync_w-1:0] pins;
  assign pins = {resume_seen, bus_activity, a_bus_power_valid_cmp,
                 b_session_end_cmp, session_valid_cmp, line_j, line_se0,
                 plug_type_sense};

  // Debounced pin value: changes once stages two and three agree
  logic [sync_w-1:0] pin_v;
  genvar gi;
  generate
    for (gi = 0; gi < sync_w; gi++) begin : g_pin
      assign pin_v[gi] = (st_reg.s2[gi] == st_reg.s3[gi]) ?
                         st_reg.s3[gi] : st_reg.in_q[gi];
    end
  endgenerate

  // Line state formed from se0 and J
  assign line_changed = (pin_v[2:1] != st_reg.in_q[2:1]);
  assign bus_changed  = line_changed | pin_v[6];

  line_idle_timer #(.limit(otg_pkg::stable_cycles)) u_stable (
    .pclk    (pclk),
    .presetn (presetn),
    .changed (line_changed),
    .reached (stable_hit)
  );

  line_idle_timer #(.limit(otg_pkg::idle_cycles)) u_idle (
    .pclk    (pclk),
    .presetn (presetn),
    .changed (bus_changed),
    .reached (idle_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  logic [5:0]  sel;
  logic        wr;
  logic [7:0]  stat;
  logic [7:0]  rd;
  logic        host_en;
  logic        func_en;
  logic        full_spd;
  logic        irq_rst_q;
  logic        irq_att_q;

  assign sel = decode(paddr);
  assign wr  = psel & penable & pwrite & ~st_reg.pready;

  always_comb begin
    st_next        = st_reg;
    st_next.s1     = pins;
    st_next.s2     = st_reg.s1;
    st_next.s3     = st_reg.s2;
    st_next.in_q   = pin_v;
    st_next.pready = 1'b0;
    host_en  = st_reg.role[otg_pkg::role_host_en_bit];
    func_en  = st_reg.role[otg_pkg::role_func_en_bit];
    full_spd = ~st_reg.role[otg_pkg::role_low_spd_bit];
    irq_rst_q = bus_reset_irq_flag;
    irq_att_q = attach_irq_flag;

    // Status byte from synchronised sense lines
    stat = 8'h00;
    stat[otg_pkg::stat_plug_bit]    = pin_v[0];
    stat[otg_pkg::stat_stable_bit]  = stable_hit;
    stat[otg_pkg::stat_sessvld_bit] = pin_v[3];
    stat[otg_pkg::stat_sessend_bit] = pin_v[4];
    stat[otg_pkg::stat_busvld_bit]  = pin_v[5];

    // Activity pending set by hardware only under sleep guard
    if (st_reg.power[otg_pkg::pwr_guard_bit] && pin_v[6]) begin
      st_next.power[otg_pkg::pwr_pending_bit] = 1'b1;
    end else if (!st_reg.power[otg_pkg::pwr_guard_bit]) begin
      st_next.power[otg_pkg::pwr_pending_bit] = 1'b0;
    end

    // Resume or bus activity wakes the module out of suspend
    if (pin_v[7] || pin_v[6]) begin
      st_next.power[otg_pkg::pwr_suspend_bit] = 1'b0;
    end

    // Read mux, only low byte carries data
    rd = 8'h00;
    if (sel[0]) begin
      rd = stat;
    end else if (sel[1]) begin
      rd = st_reg.control;
    end else if (sel[2]) begin
      rd = st_reg.power;
    end else if (sel[3]) begin
      rd = st_reg.page;
    end else if (sel[4]) begin
      rd = st_reg.role;
    end else if (sel[5]) begin
      rd = {5'h00, 3'(st_reg.fsm)};
    end

    // APB access phase, one wait state
    if (psel && penable && !st_reg.pready) begin
      st_next.pready  = 1'b1;
      st_next.pslverr = (sel == 6'h00);
      st_next.prdata  = {24'h000000, rd};
      if (wr && sel[1]) begin
        st_next.control = pwdata[7:0];
      end else if (wr && sel[2]) begin
        st_next.power = (st_reg.power & ~otg_pkg::pwr_write_mask) |
                        (pwdata[7:0] & otg_pkg::pwr_write_mask);
        if (pwdata[otg_pkg::pwr_pending_bit]) begin
          st_next.power[otg_pkg::pwr_pending_bit] = 1'b1;
        end
        if (st_reg.power[otg_pkg::pwr_guard_bit] && pin_v[6]) begin
          st_next.power[otg_pkg::pwr_pending_bit] = 1'b1;
        end
      end else if (wr && sel[3]) begin
        st_next.page = {pwdata[7:1], 1'b0};
      end else if (wr && sel[4]) begin
        st_next.role = pwdata[7:0];
      end
    end

    // Role negotiation sequencer
    case (st_reg.fsm)
      otg_pkg::st_idle: begin
        st_next.rst_drv = 1'b0;
        st_next.halt    = 1'b0;
        if (full_spd && st_reg.role[otg_pkg::role_swap_ok_bit]) begin
          if (!st_reg.role[otg_pkg::role_a_dev_bit] && idle_hit) begin
            st_next.fsm = otg_pkg::st_b_disc;
          end else if (st_reg.role[otg_pkg::role_a_dev_bit] &&
                       irq_rst_q) begin
            st_next.fsm = otg_pkg::st_a_periph;
          end
        end
      end
      otg_pkg::st_b_disc: begin
        if (irq_att_q) begin
          st_next.fsm     = otg_pkg::st_b_host_rst;
          st_next.rst_drv = 1'b1;
        end else if (pin_v[7]) begin
          st_next.fsm = otg_pkg::st_idle;
        end
      end
      otg_pkg::st_b_host_rst: begin
        st_next.rst_drv = st_reg.role[otg_pkg::role_bus_rst_bit];
        if (!st_reg.role[otg_pkg::role_bus_rst_bit]) begin
          st_next.fsm = otg_pkg::st_b_host;
        end
      end
      otg_pkg::st_b_host: begin
        if (!st_reg.role[otg_pkg::role_swap_ok_bit]) begin
          st_next.halt = 1'b1;
          st_next.fsm  = otg_pkg::st_idle;
        end
      end
      otg_pkg::st_a_periph: begin
        if (st_reg.role[otg_pkg::role_resume_bit]) begin
          st_next.fsm = otg_pkg::st_idle;
        end else if (idle_hit) begin
          st_next.fsm = otg_pkg::st_a_wait_idle;
        end
      end
      otg_pkg::st_a_wait_idle: begin
        if (irq_att_q) begin
          st_next.fsm     = otg_pkg::st_a_host_rst;
          st_next.rst_drv = 1'b1;
        end
      end
      otg_pkg::st_a_host_rst: begin
        st_next.rst_drv = st_reg.role[otg_pkg::role_bus_rst_bit];
        if (!st_reg.role[otg_pkg::role_bus_rst_bit]) begin
          st_next.fsm = otg_pkg::st_idle;
        end
      end
      default: begin
        st_next.fsm = otg_pkg::st_idle;
      end
    endcase

    // Pull resistors: direct from control or derived from role bits
    if (st_reg.control[otg_pkg::con_otg_en_bit]) begin
      st_next.pu_dp = st_reg.control[otg_pkg::con_dp_up_bit];
      st_next.pu_dm = st_reg.control[otg_pkg::con_dm_up_bit];
      st_next.pd_dp = st_reg.control[otg_pkg::con_dp_down_bit];
      st_next.pd_dm = st_reg.control[otg_pkg::con_dm_down_bit];
    end else begin
      st_next.pu_dp = func_en & ~host_en;
      st_next.pu_dm = 1'b0;
      st_next.pd_dp = host_en;
      st_next.pd_dm = host_en;
    end

    // Sequencer overrides of the pull-ups
    if (st_reg.fsm == otg_pkg::st_b_disc ||
        st_reg.fsm == otg_pkg::st_b_host_rst ||
        st_reg.fsm == otg_pkg::st_b_host) begin
      st_next.pu_dp = 1'b0;
      st_next.pu_dm = 1'b0;
    end else if (st_reg.fsm == otg_pkg::st_a_periph) begin
      st_next.pu_dp = 1'b1;
    end else if (st_reg.fsm == otg_pkg::st_a_wait_idle ||
                 st_reg.fsm == otg_pkg::st_a_host_rst) begin
      st_next.pu_dp = 1'b0;
    end
    if (st_reg.halt) begin
      st_next.pu_dp = 1'b1;
    end

    // Bus power controls
    st_next.vbus_on = st_reg.control[otg_pkg::con_bus_on_bit];
    st_next.chg_sel = st_reg.control[otg_pkg::con_chg_sel_bit];
    st_next.dischg  = st_reg.control[otg_pkg::con_dischg_bit];

    // Module power and suspend
    st_next.clk_gate = st_reg.power[otg_pkg::pwr_suspend_bit] |
                       ~st_reg.power[otg_pkg::pwr_enable_bit];
    st_next.low_pwr  = st_reg.power[otg_pkg::pwr_suspend_bit];
    st_next.host = (st_reg.fsm == otg_pkg::st_b_host) |
                   (st_reg.fsm == otg_pkg::st_b_host_rst) |
                   (host_en && st_reg.fsm == otg_pkg::st_idle);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg         <= '0;
      st_reg.control <= otg_pkg::control_rst;
      st_reg.power   <= otg_pkg::power_rst;
      st_reg.page    <= otg_pkg::page_rst;
      st_reg.role    <= otg_pkg::role_rst;
      st_reg.fsm     <= otg_pkg::st_idle;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops
  assign prdata                 = st_reg.prdata;
  assign pready                 = st_reg.pready;
  assign pslverr                = st_reg.pslverr;
  assign dplus_pullup_en        = st_reg.pu_dp;
  assign dminus_pullup_en       = st_reg.pu_dm;
  assign dplus_pulldown_en      = st_reg.pd_dp;
  assign dminus_pulldown_en     = st_reg.pd_dm;
  assign bus_power_on           = st_reg.vbus_on;
  assign bus_charge_level_sel   = st_reg.chg_sel;
  assign bus_power_discharge_en = st_reg.dischg;
  assign usb_clock_gate         = st_reg.clk_gate;
  assign xcvr_low_power         = st_reg.low_pwr;
  assign bus_reset_drive        = st_reg.rst_drv;
  assign traffic_halt           = st_reg.halt;
  assign host_active            = st_reg.host;
  assign descriptor_table_page  = st_reg.page;

endmodule : otg_role_swap_power_control

// ===== bench/otg_role_swap_power_control_properties.sv
// Port checker for the dual-role port control block
`timescale 1ns/1ps
module otg_role_swap_power_control_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        plug_type_sense,
  input wire logic        line_se0,
  input wire logic        line_j,
  input wire logic        session_valid_cmp,
  input wire logic        b_session_end_cmp,
  input wire logic        a_bus_power_valid_cmp,
  input wire logic        dplus_pullup_en,
  input wire logic        dminus_pullup_en,
  input wire logic        dplus_pulldown_en,
  input wire logic        dminus_pulldown_en,
  input wire logic        bus_power_on,
  input wire logic        bus_charge_level_sel,
  input wire logic        bus_power_discharge_en,
  input wire logic        usb_clock_gate,
  input wire logic        xcvr_low_power,
  input wire logic [7:0]  descriptor_table_page
);
  logic       ctl_wr;
  logic       stat_rd;
  logic [7:0] ctl_reg;
  logic [5:0] seen_reg;
  int         line_quiet_reg;
  int         sense_quiet_reg;
  // Completed control write with dual-role enable (bit 2) set, and completed status read
  assign ctl_wr  = psel && penable && pready && pwrite && pwdata[2]
                   && paddr == otg_pkg::control_addr;
  assign stat_rd = psel && penable && pready && !pwrite
                   && paddr == otg_pkg::status_addr;
  // Last control value and cycles since inputs moved, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_reg         <= 8'h00;
      seen_reg        <= 6'h00;
      line_quiet_reg  <= 0;
      sense_quiet_reg <= 0;
    end else begin
      if (ctl_wr) ctl_reg <= pwdata[7:0];
      seen_reg <= {line_se0, line_j, plug_type_sense, session_valid_cmp,
                   b_session_end_cmp, a_bus_power_valid_cmp};
      if (seen_reg[5:4] != {line_se0, line_j}) line_quiet_reg <= 0;
      else if (line_quiet_reg < 30000) line_quiet_reg <= line_quiet_reg + 1;
      if (seen_reg[3:0] != {plug_type_sense, session_valid_cmp,
                            b_session_end_cmp, a_bus_power_valid_cmp})
        sense_quiet_reg <= 0;
      else if (sense_quiet_reg < 20) sense_quiet_reg <= sense_quiet_reg + 1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ctl_wr;
    ctl_wr;
  endsequence
  property p_upper_zero;
    pready |-> prdata[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read bits not zero");
  property p_line_stable;
    stat_rd |-> (prdata[5] ? line_quiet_reg >= otg_pkg::stable_cycles
                           : line_quiet_reg < otg_pkg::stable_cycles + 10);
  endproperty
  a_line_stable: assert property (p_line_stable)
    else $error("line stable flag wrong");
  property p_plug;
    stat_rd && sense_quiet_reg >= 10 |-> prdata[7] == plug_type_sense;
  endproperty
  a_plug: assert property (p_plug)
    else $error("plug bit wrong");
  property p_cmp;
    stat_rd && sense_quiet_reg >= 10 |-> {prdata[6], prdata[4:0]} == {2'h0,
      session_valid_cmp, b_session_end_cmp, 1'b0, a_bus_power_valid_cmp};
  endproperty
  a_cmp: assert property (p_cmp)
    else $error("comparator bits wrong");
  property p_page;
    descriptor_table_page[0] == 1'b0;
  endproperty
  a_page: assert property (p_page)
    else $error("page bit zero set");
  property p_pulls;
    s_ctl_wr |-> ##[1:2] {dplus_pullup_en, dminus_pullup_en,
      dplus_pulldown_en, dminus_pulldown_en} == ctl_reg[7:4];
  endproperty
  a_pulls: assert property (p_pulls)
    else $error("pull pins differ from control");
  property p_power;
    s_ctl_wr |-> ##[1:2] {bus_power_on, bus_charge_level_sel,
      bus_power_discharge_en} == {ctl_reg[3], ctl_reg[1:0]};
  endproperty
  a_power: assert property (p_power)
    else $error("bus power pins differ from control");
  property p_gate;
    xcvr_low_power |-> usb_clock_gate;
  endproperty
  a_gate: assert property (p_gate)
    else $error("low power without clock gate");
endmodule : otg_role_swap_power_control_properties
bind otg_role_swap_power_control otg_role_swap_power_control_properties
  props_inst (.*);

// ===== bench/otg_far_end_model.sv
// Far-end dual-role device as seen across the data lines
`timescale 1ns/1ps
module otg_far_end_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic dplus_pullup_en,
  input  wire logic dminus_pullup_en,
  input  wire logic far_connect,
  input  wire logic far_resume,
  output logic      line_se0,
  output logic      line_j,
  output logic      attach_irq_flag,
  output logic      bus_reset_irq_flag,
  output logic      resume_seen
);
  logic connect_reg;
  logic se0_reg;
  // D+ pull-up or far connect gives J; with neither and no D- pull-up the pull-downs leave SE0
  assign line_j      = dplus_pullup_en | far_connect;
  assign line_se0    = !(line_j | dminus_pullup_en);
  assign resume_seen = far_resume;
  // Flags pulse on a far connect or when the line falls to SE0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      connect_reg        <= 1'b0;
      se0_reg            <= 1'b0;
      attach_irq_flag    <= 1'b0;
      bus_reset_irq_flag <= 1'b0;
    end else begin
      connect_reg        <= far_connect;
      se0_reg            <= line_se0;
      attach_irq_flag    <= far_connect && !connect_reg;
      bus_reset_irq_flag <= line_se0 && !se0_reg;
    end
  end
endmodule : otg_far_end_model

// ===== bench/tb_otg_role_swap_power_control.sv
// Self-checking bench for the dual-role port control block
`timescale 1ns/1ps
module tb_otg_role_swap_power_control;
  typedef struct packed {
    logic [3:0]  sense;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] exp;
    logic        err;
  } row_s;
  localparam row_s rows [16] = '{
    '{4'hd, 1'b0, otg_pkg::control_addr, 32'h0, 32'h00, 1'b0},
    '{4'hd, 1'b0, otg_pkg::power_addr, 32'h0, 32'h00, 1'b0},
    '{4'hd, 1'b0, otg_pkg::status_addr, 32'h0, 32'h89, 1'b0},
    '{4'h6, 1'b0, otg_pkg::status_addr, 32'h0, 32'h0c, 1'b0},
    '{4'hd, 1'b1, otg_pkg::status_addr, 32'hff, 32'h0, 1'b0},
    '{4'hd, 1'b0, otg_pkg::status_addr, 32'h0, 32'h89, 1'b0},
    '{4'hd, 1'b1, otg_pkg::control_addr, 32'ha5a5a5f7, 32'h0, 1'b0},
    '{4'hd, 1'b0, otg_pkg::control_addr, 32'h0, 32'hf7, 1'b0},
    '{4'hd, 1'b1, otg_pkg::page_addr, 32'hffffffff, 32'h0, 1'b0},
    '{4'hd, 1'b0, otg_pkg::page_addr, 32'h0, 32'hfe, 1'b0},
    '{4'hd, 1'b1, otg_pkg::role_addr, 32'h18, 32'h0, 1'b0},
    '{4'hd, 1'b0, otg_pkg::role_st_addr, 32'h0, 32'h0, 1'b0},
    '{4'hd, 1'b1, 8'h18, 32'h1, 32'h0, 1'b1},
    '{4'hd, 1'b0, 8'h18, 32'h0, 32'h0, 1'b1},
    '{4'hd, 1'b1, otg_pkg::power_addr, 32'h11, 32'h0, 1'b0},
    '{4'hd, 1'b0, otg_pkg::power_addr, 32'h0, 32'h11, 1'b0}};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        plug_type_sense = 1'b1;
  logic        session_valid_cmp = 1'b1;
  logic        b_session_end_cmp = 1'b0;
  logic        a_bus_power_valid_cmp = 1'b1;
  logic        far_connect = 1'b0;
  logic        far_resume = 1'b0;
  logic        line_se0, line_j, attach_irq_flag, bus_reset_irq_flag;
  logic        resume_seen, usb_clock_gate, xcvr_low_power, traffic_halt;
  logic        dplus_pullup_en, dminus_pullup_en, dplus_pulldown_en;
  logic        dminus_pulldown_en, bus_power_on, bus_charge_level_sel;
  logic        bus_power_discharge_en, bus_reset_drive, host_active;
  logic        bus_activity = 1'b0;
  logic [7:0]  descriptor_table_page;
  logic [7:0]  pins;
  logic [31:0] q;
  logic        e;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  assign pins = {dplus_pullup_en, dminus_pullup_en, dplus_pulldown_en,
                 dminus_pulldown_en, bus_power_on, 1'b0,
                 bus_charge_level_sel, bus_power_discharge_en};
  otg_role_swap_power_control otg_role_swap_power_control_inst (.*);
  otg_far_end_model otg_far_end_model_inst (.*);
  ////////////////////////////////////////////////////////////////////////
  // Clock and hang limit
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 90000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // One bus transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////
  // Table of register accesses, then the hand-written cases
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      {plug_type_sense, session_valid_cmp, b_session_end_cmp,
       a_bus_power_valid_cmp} <= rows[i].sense;
      repeat (12) @(posedge pclk);
      apb(rows[i].wr, rows[i].addr, rows[i].wdata);
      if (!rows[i].wr) check("read", rows[i].exp, q);
      check("error", {31'h0, rows[i].err}, {31'h0, e});
    end
    $display("test table done");
    check("page pins", 32'hfe, {24'h0, descriptor_table_page});
    bus_activity <= 1'b1;
    repeat (8) @(posedge pclk);
    bus_activity <= 1'b0;
    apb(1'b0, otg_pkg::power_addr, 32'h0);
    check("pending", 32'h91, q);
    apb(1'b1, otg_pkg::role_addr, 32'h1);
    for (int b = 0; b < 8; b++) begin
      if (b == 2) continue;
      apb(1'b1, otg_pkg::control_addr, 32'h4 | (32'h1 << b));
      repeat (3) @(posedge pclk);
      check("pins", 32'h1 << b, {24'h0, pins});
    end
    apb(1'b1, otg_pkg::control_addr, 32'h0);
    apb(1'b1, otg_pkg::role_addr, 32'h2);
    repeat (3) @(posedge pclk);
    check("function pulls", 32'h80, {24'h0, pins});
    apb(1'b1, otg_pkg::role_addr, 32'h1);
    repeat (3) @(posedge pclk);
    check("host pulls", 32'h30, {24'h0, pins});
    apb(1'b1, otg_pkg::role_addr, 32'h0);
    $display("test pulls done");
    repeat (otg_pkg::stable_cycles + 20) @(posedge pclk);
    apb(1'b0, otg_pkg::status_addr, 32'h0);
    check("stable", 32'ha9, q);
    far_connect <= 1'b1;
    repeat (12) @(posedge pclk);
    apb(1'b0, otg_pkg::status_addr, 32'h0);
    check("unstable", 32'h89, q);
    far_connect <= 1'b0;
    $display("test line done");
    apb(1'b1, otg_pkg::power_addr, 32'h3);
    repeat (3) @(posedge pclk);
    check("suspend", 32'h3, {30'h0, usb_clock_gate, xcvr_low_power});
    far_resume <= 1'b1;
    for (int n = 0; n < 50 && xcvr_low_power !== 1'b0; n++) @(posedge pclk);
    far_resume <= 1'b0;
    apb(1'b0, otg_pkg::power_addr, 32'h0);
    check("resumed", 32'h1, q);
    check("awake", 32'h0, {30'h0, usb_clock_gate, xcvr_low_power});
    $display("test suspend done");
    apb(1'b1, otg_pkg::role_addr, 32'h48);
    repeat (otg_pkg::idle_cycles + 20) @(posedge pclk);
    apb(1'b0, otg_pkg::role_st_addr, 32'h0);
    check("swap state", 32'h1, q);
    far_connect <= 1'b1;
    repeat (4) @(posedge pclk);
    check("host reset", 32'h3, {30'h0, bus_reset_drive, host_active});
    apb(1'b1, otg_pkg::role_addr, 32'h8);
    apb(1'b0, otg_pkg::role_st_addr, 32'h0);
    check("host state", 32'h3, q);
    $display("test swap done");
    test_done();
  end
endmodule : tb_otg_role_swap_power_control
